/* File: shared/ebla_pkg.sv */
// package: widths, encodings and lane layout for the byte-lane aligner
package ebla_pkg;
  // access sizes from the requester
  typedef enum logic [1:0] {
    EBLA_SZ_BYTE = 2'h0,
    EBLA_SZ_WORD = 2'h1,
    EBLA_SZ_LONG = 2'h2
  } ebla_size_e;

  // external device widths
  typedef enum logic [1:0] {
    EBLA_DW_8  = 2'h0,
    EBLA_DW_16 = 2'h1,
    EBLA_DW_32 = 2'h2
  } ebla_width_e;

  // memory type of the accessed area, picks strobe meaning
  typedef enum logic [1:0] {
    EBLA_MT_NORMAL = 2'h0,
    EBLA_MT_DRAM   = 2'h1,
    EBLA_MT_SDRAM  = 2'h2
  } ebla_mtype_e;

  // sequencer states, gray along idle -> busy
  typedef enum logic [1:0] {
    EBLA_ST_IDLE = 2'h0,
    EBLA_ST_BUSY = 2'h1
  } ebla_state_e;

  localparam int          EBLA_DATA_W   = 32;
  localparam int          EBLA_ADDR_W   = 32;
  localparam logic        EBLA_BIG      = 1'b0;  // pin low = big endian
  localparam logic [1:0]  EBLA_CNT_ZERO = 2'h0;

  // internal request
  typedef struct packed {
    logic [EBLA_ADDR_W-1:0] addr;
    ebla_size_e             size;
    logic                   write;
    logic [EBLA_DATA_W-1:0] wdata;  // right-justified
  } ebla_req_s;

  // one external bus cycle
  typedef struct packed {
    logic [EBLA_ADDR_W-1:0] addr;
    logic                   write;
    logic [EBLA_DATA_W-1:0] data;
    logic [3:0]             lanes;  // lane enable, bit n = lane n
  } ebla_ext_s;
endpackage

/* File: hw/ebla_aligner.sv */
// byte-lane steering and access splitting for the external bus
`timescale 1ns/1ps
module ebla_aligner (
  // clock and reset
  input  wire logic                  core_clk_i,
  input  wire logic                  nrst_i,
  // strap
  input  wire logic                  endian_select_pin_i,
  // configuration of the accessed area
  input  wire ebla_pkg::ebla_width_e dev_width_i,
  input  wire ebla_pkg::ebla_mtype_e mem_type_i,
  // internal request side
  input  wire logic                  req_valid_i,
  output logic                       req_ready_o,
  input  wire ebla_pkg::ebla_req_s   req_i,
  output logic                       rsp_valid_o,
  output logic [31:0]                rsp_rdata_o,
  // external bus side
  output logic                       ext_valid_o,
  input  wire logic                  ext_ready_i,
  output ebla_pkg::ebla_ext_s        ext_o,
  input  wire logic [31:0]           ext_rdata_i,
  // lane strobes, active low; data masks active high (high = masked)
  output logic                       lane3_write_strobe_n_o,
  output logic                       lane2_write_strobe_n_o,
  output logic                       lane1_write_strobe_n_o,
  output logic                       lane0_write_strobe_n_o,
  output logic                       lane3_column_strobe_n_o,
  output logic                       lane2_column_strobe_n_o,
  output logic                       lane1_column_strobe_n_o,
  output logic                       lane0_column_strobe_n_o,
  output logic                       lane3_data_mask_o,
  output logic                       lane2_data_mask_o,
  output logic                       lane1_data_mask_o,
  output logic                       lane0_data_mask_o,
  // endian mode in force
  output logic                       little_endian_o
);

  // state
  ebla_pkg::ebla_state_e  state_r, state_nxt;
  ebla_pkg::ebla_req_s    req_r;
  ebla_pkg::ebla_width_e  width_r;
  logic [1:0]             cnt_r, cnt_nxt;   // current sub-access
  logic [1:0]             last_r;           // index of last sub-access
  logic                   strap_done_r;
  logic                   le_r;
  logic [31:0]            acc_r, acc_nxt;   // read assembly

  // number of sub-accesses minus one
  function automatic logic [1:0] last_idx(ebla_pkg::ebla_size_e sz,
                                          ebla_pkg::ebla_width_e w);
    logic [1:0] r;
    r = 2'h0;
    if (w == ebla_pkg::EBLA_DW_8)
      r = (sz == ebla_pkg::EBLA_SZ_LONG) ? 2'h3 :
          (sz == ebla_pkg::EBLA_SZ_WORD) ? 2'h1 : 2'h0;
    else if (w == ebla_pkg::EBLA_DW_16)
      r = (sz == ebla_pkg::EBLA_SZ_LONG) ? 2'h1 : 2'h0;
    return r;
  endfunction

  // byte index within the value (0 = least significant) for address-order
  // position k (0 = lowest address of the request); le picks order
  function automatic logic [1:0] pick(logic le, logic [1:0] nbytes_m1,
                                      logic [1:0] k);
    return le ? k : 2'(nbytes_m1 - k);
  endfunction

  // sub-access geometry
  logic [1:0]  sub_bytes_m1;   // bytes per sub-access minus one
  logic [1:0]  tot_bytes_m1;   // bytes in whole request minus one
  logic [1:0]  sub_off;        // address offset of this sub-access
  logic [1:0]  sub_addr;       // low address bits of this sub-access
  logic [1:0]  base_lane;      // lowest lane used
  logic [3:0]  lanes;
  logic [31:0] wbus;
  logic [31:0] rpart;
  logic        is_last;

  assign tot_bytes_m1 = (req_r.size == ebla_pkg::EBLA_SZ_LONG) ? 2'h3 :
                        (req_r.size == ebla_pkg::EBLA_SZ_WORD) ? 2'h1 :
                        2'h0;
  assign sub_bytes_m1 = (width_r == ebla_pkg::EBLA_DW_8) ? 2'h0 :
                        (width_r == ebla_pkg::EBLA_DW_16 &&
                         tot_bytes_m1 == 2'h3) ? 2'h1 : tot_bytes_m1;
  // ascending address order of sub-accesses
  assign sub_off  = (width_r == ebla_pkg::EBLA_DW_8) ? cnt_r :
                    {cnt_r[0], 1'b0};
  assign sub_addr = 2'(req_r.addr[1:0] + sub_off);
  assign is_last  = (cnt_r == last_r);

  // lane placement: 8-bit uses lane0 16-bit uses lanes 1:0
  // BE even byte on lane1 32-bit BE mirrors, LE straight
  always_comb begin
    base_lane = 2'h0;
    if (width_r == ebla_pkg::EBLA_DW_16) begin
      if (sub_bytes_m1 == 2'h0)
        base_lane = {1'b0, sub_addr[0] ^ ~le_r};
    end else if (width_r == ebla_pkg::EBLA_DW_32) begin
      if (le_r)
        base_lane = sub_addr;
      else
        base_lane = 2'(2'h3 - sub_addr - sub_bytes_m1);
    end
  end

  // data steering: byte k of the sub-unit on lane base_lane+k;
  // the sub-unit holds value bytes chosen by endian and order
  always_comb begin
    lanes = 4'h0;
    wbus  = 32'h0;
    rpart = acc_r;
    for (int k = 0; k < 4; k++) begin
      logic [1:0] ln;
      logic [1:0] vb;
      logic [1:0] pos;
      ln  = 2'(base_lane + k[1:0]);
      // position in address order within the request
      pos = le_r ? 2'(sub_off + k[1:0])
                 : 2'(sub_off + sub_bytes_m1 - k[1:0]);
      vb  = pick(le_r, tot_bytes_m1, pos);
      if (2'(k) <= sub_bytes_m1) begin
        lanes[ln]         = 1'b1;
        wbus[ln*8 +: 8]   = req_r.wdata[vb*8 +: 8];
        rpart[vb*8 +: 8]  = ext_rdata_i[ln*8 +: 8];
      end
    end
  end

  // sequencing: one request becomes 1, 2 or 4 bus cycles
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    acc_nxt   = acc_r;
    case (state_r)
      ebla_pkg::EBLA_ST_IDLE: begin
        if (req_valid_i && strap_done_r) begin
          state_nxt = ebla_pkg::EBLA_ST_BUSY;
          cnt_nxt   = ebla_pkg::EBLA_CNT_ZERO;
          acc_nxt   = 32'h0;
        end
      end
      ebla_pkg::EBLA_ST_BUSY: begin
        if (ext_ready_i) begin
          acc_nxt = rpart;
          cnt_nxt = 2'(cnt_r + 2'h1);
          if (is_last)
            state_nxt = ebla_pkg::EBLA_ST_IDLE;
        end
      end
      default: state_nxt = ebla_pkg::EBLA_ST_IDLE;
    endcase
  end

  assign req_ready_o = (state_r == ebla_pkg::EBLA_ST_IDLE) && strap_done_r;
  assign ext_valid_o = (state_r == ebla_pkg::EBLA_ST_BUSY);
  assign ext_o.addr  = {req_r.addr[31:2], sub_addr};
  assign ext_o.write = req_r.write;
  assign ext_o.data  = wbus;
  assign ext_o.lanes = lanes;

  // strobe meaning follows memory type of the area
  wire en = ext_valid_o;
  wire nm = en && mem_type_i == ebla_pkg::EBLA_MT_NORMAL && req_r.write;
  wire dr = en && mem_type_i == ebla_pkg::EBLA_MT_DRAM;
  wire sd = en && mem_type_i == ebla_pkg::EBLA_MT_SDRAM;
  assign lane3_write_strobe_n_o  = ~(nm & lanes[3]);
  assign lane2_write_strobe_n_o  = ~(nm & lanes[2]);
  assign lane1_write_strobe_n_o  = ~(nm & lanes[1]);
  assign lane0_write_strobe_n_o  = ~(nm & lanes[0]);
  assign lane3_column_strobe_n_o = ~(dr & lanes[3]);
  assign lane2_column_strobe_n_o = ~(dr & lanes[2]);
  assign lane1_column_strobe_n_o = ~(dr & lanes[1]);
  assign lane0_column_strobe_n_o = ~(dr & lanes[0]);
  assign lane3_data_mask_o       = ~(sd & lanes[3]);  // high = masked
  assign lane2_data_mask_o       = ~(sd & lanes[2]);
  assign lane1_data_mask_o       = ~(sd & lanes[1]);
  assign lane0_data_mask_o       = ~(sd & lanes[0]);
  assign little_endian_o         = le_r;

  // endian strap caught on first edge after reset release
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      strap_done_r <= 1'b0;
      le_r         <= 1'b0;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      le_r         <= (endian_select_pin_i != ebla_pkg::EBLA_BIG);
    end
  end

  // request capture and sequencer registers
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= ebla_pkg::EBLA_ST_IDLE;
      cnt_r   <= 2'h0;
      last_r  <= 2'h0;
      acc_r   <= 32'h0;
      req_r   <= '0;
      width_r <= ebla_pkg::EBLA_DW_32;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      acc_r   <= acc_nxt;
      if (req_valid_i && req_ready_o) begin
        req_r   <= req_i;
        width_r <= dev_width_i;
        last_r  <= last_idx(req_i.size, dev_width_i);
      end
    end
  end

  // read answer after the last sub-access
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= 32'h0;
    end else begin
      rsp_valid_o <= ext_valid_o && ext_ready_i && is_last;
      if (ext_valid_o && ext_ready_i && is_last)
        rsp_rdata_o <= rpart;
    end
  end

  // 16-bit BE longword: first cycle at offset 0 on lanes 1:0
  a_be16_long_split: assert property (@(posedge core_clk_i)
    disable iff (!nrst_i)
    (ext_valid_o && !le_r && width_r == ebla_pkg::EBLA_DW_16 &&
     req_r.size == ebla_pkg::EBLA_SZ_LONG && cnt_r == 2'h0)
    |-> (lanes == 4'h3 && ext_o.data[15:0] == req_r.wdata[31:16]))
    else $error("16-bit big-endian longword first half wrong");

  // 8-bit device only ever uses lane 0
  a_byte_dev_lane: assert property (@(posedge core_clk_i)
    disable iff (!nrst_i)
    (ext_valid_o && width_r == ebla_pkg::EBLA_DW_8) |-> lanes == 4'h1)
    else $error("8-bit device used a lane other than 0");

  // 32-bit little-endian longword in one cycle with all lanes
  a_le32_long_one: assert property (@(posedge core_clk_i)
    disable iff (!nrst_i)
    (ext_valid_o && le_r && width_r == ebla_pkg::EBLA_DW_32 &&
     req_r.size == ebla_pkg::EBLA_SZ_LONG)
    |-> (lanes == 4'hf && is_last && ext_o.data == req_r.wdata))
    else $error("32-bit longword not single full cycle");

  // 32-bit little-endian byte lands on lane equal to its address
  a_le32_byte_lane: assert property (@(posedge core_clk_i)
    disable iff (!nrst_i)
    (ext_valid_o && le_r && width_r == ebla_pkg::EBLA_DW_32 &&
     req_r.size == ebla_pkg::EBLA_SZ_BYTE)
    |-> lanes == 4'(4'h1 << req_r.addr[1:0]))
    else $error("32-bit little-endian byte on wrong lane");

  // 16-bit big-endian byte: even address on lane 1, odd on lane 0
  a_be16_byte_lane: assert property (@(posedge core_clk_i)
    disable iff (!nrst_i)
    (ext_valid_o && !le_r && width_r == ebla_pkg::EBLA_DW_16 &&
     req_r.size == ebla_pkg::EBLA_SZ_BYTE)
    |-> lanes == (req_r.addr[0] ? 4'h1 : 4'h2))
    else $error("16-bit big-endian byte on wrong lane");

  // 32-bit little-endian word: address 0 low lanes, address 2 high
  a_le32_word_lanes: assert property (@(posedge core_clk_i)
    disable iff (!nrst_i)
    (ext_valid_o && le_r && width_r == ebla_pkg::EBLA_DW_32 &&
     req_r.size == ebla_pkg::EBLA_SZ_WORD)
    |-> lanes == (req_r.addr[1] ? 4'hc : 4'h3))
    else $error("32-bit little-endian word on wrong lanes");

  // 8-bit device: a finished sub-access that is not the last one
  sequence s_byte_step_done;
    ext_valid_o && ext_ready_i && width_r == ebla_pkg::EBLA_DW_8 && !is_last;
  endsequence

  // the following sub-access sits one address higher
  a_byte_dev_order: assert property (@(posedge core_clk_i)
    disable iff (!nrst_i)
    s_byte_step_done |=> (ext_valid_o &&
      ext_o.addr[1:0] == 2'($past(ext_o.addr[1:0]) + 2'h1)))
    else $error("8-bit device sub-accesses not ascending");
endmodule

/* File: bench/ebla_mem_model.sv */
// external memory model: random answer delay, byte store keyed by lane
`timescale 1ns/1ps
module ebla_mem_model (
  // clock
  input  wire logic                core_clk_i,
  // bus from the aligner
  input  wire logic                ext_valid_i,
  input  wire ebla_pkg::ebla_ext_s ext_i,
  // answer to the aligner
  output logic                     ext_ready_o,
  output logic [31:0]              ext_rdata_o
);
  logic [7:0]  mem [logic [33:0]];
  logic [31:0] rnd_r = 32'h1357acef;
  logic [1:0]  dly_r = 2'h0;

  initial begin
    ext_ready_o = 1'b0;
    ext_rdata_o = 32'h0;
  end

  // answer at a falling edge; idle data lines change every cycle
  always @(negedge core_clk_i) begin
    rnd_r = rnd_r ^ (rnd_r << 13);
    rnd_r = rnd_r ^ (rnd_r >> 17);
    rnd_r = rnd_r ^ (rnd_r << 5);
    ext_rdata_o <= rnd_r;
    if (ext_ready_o || !ext_valid_i) begin
      ext_ready_o <= 1'b0;
      dly_r       <= rnd_r[1:0];
    end else if (dly_r != 2'h0) begin
      dly_r <= dly_r - 2'h1;
    end else begin
      ext_ready_o <= 1'b1;
      for (int n = 0; n < 4; n++) begin
        if (mem.exists({ext_i.addr, 2'(n)}))
          ext_rdata_o[8*n +: 8] <= mem[{ext_i.addr, 2'(n)}];
      end
    end
  end

  // writes land at the edge that ends the sub-access
  always @(posedge core_clk_i) begin
    if (ext_valid_i && ext_ready_o && ext_i.write) begin
      for (int n = 0; n < 4; n++) begin
        if (ext_i.lanes[n]) mem[{ext_i.addr, 2'(n)}] = ext_i.data[8*n +: 8];
      end
    end
  end
endmodule

/* File: bench/ebla_tb_top.sv */
// self-checking bench for the byte-lane aligner
`timescale 1ns/1ps
module external_bus_byte_lane_alignment_tb_top;
  logic clk = 1'b0, nrst = 1'b0, pin = 1'b0, rv = 1'b0, erdy, le_c, wr_c;
  ebla_pkg::ebla_width_e dw = ebla_pkg::EBLA_DW_8;
  ebla_pkg::ebla_mtype_e mt = ebla_pkg::EBLA_MT_NORMAL;
  ebla_pkg::ebla_req_s   rq = '0;
  ebla_pkg::ebla_ext_s   ext, e;
  logic [31:0] seed = 32'h4e21abdc, rdat, erd, m, a_c, wd_c;
  logic [1:0]  sz_c;
  logic        rdy, rspv, ev, le;
  wire  [3:0]  wrn, coln, msk;
  int          errors = 0, checked = 0, idx = 0, base = 0;

  // clock at 40 mhz
  initial forever #12.5 clk = ~clk;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // number of external cycles for one request
  function automatic int n_sub(logic l, logic [1:0] s);
    if (l) return 1;
    if (dw == ebla_pkg::EBLA_DW_16) return (s == 2'h2) ? 2 : 1;
    return (s == 2'h0) ? 1 : (s == 2'h1) ? 2 : 4;
  endfunction

  // expected address, lanes and lane data of sub-access i
  function automatic ebla_pkg::ebla_ext_s exp_sub(int i);
    ebla_pkg::ebla_ext_s x;
    x = '0;
    x.addr = a_c;
    if (le_c) begin
      x.lanes = (sz_c == 2'h2) ? 4'hf : (sz_c == 2'h1) ?
                (a_c[1] ? 4'hc : 4'h3) : 4'h1 << a_c[1:0];
      x.data = wd_c << (8 * a_c[1:0]);
    end else if (dw == ebla_pkg::EBLA_DW_16) begin
      x.addr = a_c + 2 * i;
      x.lanes = (sz_c != 2'h0) ? 4'h3 : (a_c[0] ? 4'h1 : 4'h2);
      x.data = (sz_c == 2'h2) ? ((i == 0) ? wd_c >> 16 : wd_c & 32'hffff) :
               (sz_c == 2'h1) ? wd_c : (a_c[0] ? wd_c : wd_c << 8);
    end else begin
      x.addr = a_c + i;
      x.lanes = 4'h1;
      x.data = wd_c >> (8 * (n_sub(1'b0, sz_c) - 1 - i));
    end
    return x;
  endfunction

  task automatic chk(input logic [71:0] g, input logic [71:0] x);
    checked++;
    if (g !== x) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, x);
    end
  endtask

  task automatic stop_test();
    if (errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // each finished sub-access is compared with its expectation
  always @(posedge clk) begin
    if (nrst && ev && erdy) begin
      e = exp_sub(idx - base);
      m = {{8{e.lanes[3]}}, {8{e.lanes[2]}}, {8{e.lanes[1]}}, {8{e.lanes[0]}}};
      chk({ext.write, ext.addr, ext.data & m,
           ext.lanes}, {wr_c, e.addr,
           e.data & m, e.lanes});
      chk({wrn, coln, msk},
          {(mt == ebla_pkg::EBLA_MT_NORMAL && wr_c) ? ~e.lanes : 4'hf,
           (mt == ebla_pkg::EBLA_MT_DRAM) ? ~e.lanes : 4'hf,
           (mt == ebla_pkg::EBLA_MT_SDRAM) ? ~e.lanes : 4'hf});
      idx++;
    end
  end

  // one request: offer, wait until taken, then wait for the answer
  task automatic acc(input logic [1:0] s, input logic [31:0] a,
                     input logic w, input logic [31:0] d);
    int k;
    sz_c = s; a_c = a; wr_c = w; wd_c = d;
    base = idx;
    @(negedge clk);
    rq = '{addr: a, size: ebla_pkg::ebla_size_e'(s), write: w, wdata: d};
    rv = 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (rdy) break;
    end
    @(negedge clk);
    rv = 1'b0;
    for (k = k; k < 100; k++) begin
      @(posedge clk);
      if (rspv) break;
    end
    if (k >= 100) begin
      errors++;
      stop_test();
    end
    chk(idx - base, n_sub(le_c, s));
    if (!w) chk(rdat & ((s == 2'h2) ? 32'hffffffff : (s == 2'h1) ?
                32'hffff : 32'hff), d & ((s == 2'h2) ? 32'hffffffff :
                (s == 2'h1) ? 32'hffff : 32'hff));
  endtask

  // reset with the strap at a given level, both modes in turn
  initial begin
    logic [1:0]  s;
    logic [31:0] a, d;
    for (int p = 0; p < 2; p++) begin
      @(negedge clk);
      nrst = 1'b0;
      pin = p[0];
      repeat (20) @(negedge clk);
      nrst = 1'b1;
      le_c = p[0];
      @(posedge clk);
      @(negedge clk);
      chk(le, p[0]);
      for (int i = 0; i < 64; i++) begin
        @(negedge clk);
        d = xs();
        s = (i < 4) ? 2'h0 : (i < 8) ? 2'h2 : 2'(xs() % 3);
        a = (i < 4) ? 32'(i) : xs();
        a = (s == 2'h2) ? a & 32'hfffffffc :
            (s == 2'h1) ? a & 32'hfffffffe : a;
        mt = ebla_pkg::ebla_mtype_e'(2'(xs() % 3));
        dw = p[0] ? ebla_pkg::EBLA_DW_32 : (xs() % 2 ? ebla_pkg::EBLA_DW_16 :
             ebla_pkg::EBLA_DW_8);
        acc(s, a, 1'b1, d);
        acc(s, a, 1'b0, d);
      end
    end
    stop_test();
  end

  ebla_aligner dut_u (
    .core_clk_i(clk), .nrst_i(nrst), .endian_select_pin_i(pin),
    .dev_width_i(dw), .mem_type_i(mt), .req_valid_i(rv), .req_ready_o(rdy),
    .req_i(rq), .rsp_valid_o(rspv), .rsp_rdata_o(rdat), .ext_valid_o(ev),
    .ext_ready_i(erdy), .ext_o(ext), .ext_rdata_i(erd),
    .lane3_write_strobe_n_o(wrn[3]), .lane2_write_strobe_n_o(wrn[2]),
    .lane1_write_strobe_n_o(wrn[1]), .lane0_write_strobe_n_o(wrn[0]),
    .lane3_column_strobe_n_o(coln[3]), .lane2_column_strobe_n_o(coln[2]),
    .lane1_column_strobe_n_o(coln[1]), .lane0_column_strobe_n_o(coln[0]),
    .lane3_data_mask_o(msk[3]), .lane2_data_mask_o(msk[2]),
    .lane1_data_mask_o(msk[1]), .lane0_data_mask_o(msk[0]),
    .little_endian_o(le)
  );

  ebla_mem_model mem_u (
    .core_clk_i(clk), .ext_valid_i(ev), .ext_i(ext), .ext_ready_o(erdy),
    .ext_rdata_o(erd)
  );
endmodule
